// [cos_contactor_model.sv]
// contactor bank: each pole follows its coil after a pull-in delay
`timescale 1ns/100ps
`default_nettype none
module cos_contactor_model
   import cos_pkg::*;
#(
   parameter int PULL_CYCLES = 2
)
(
   input wire logic mclk, // clock
   input wire logic [cos_pkg::N_SECT-1:0] coil, // coil drives
   output logic [cos_pkg::N_SECT-1:0] closed // pole states
);
   logic [N_SECT-1:0] pipe [0:PULL_CYCLES-1];
   always @(posedge mclk)
   begin
      pipe[0] <= coil;
      for (int i = 1; i < PULL_CYCLES; i++)
         pipe[i] <= pipe[i-1];
   end
   assign closed = pipe[PULL_CYCLES-1];
endmodule // cos_contactor_model
`default_nettype wire

// [cos_pkg.sv]
// shared constants, field layouts and types of the compensation output sequencer
package cos_pkg;
   localparam int N_SECT = 18;
   localparam int N_ALARM = 17;
   localparam int IW = 5;
   localparam int TW = 14;
   localparam int KW = 16;
   // time base
   localparam int CLK_PERIOD_NS = 4;
   localparam int SECOND_NS = 1_000_000_000;
   localparam int TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] DIS1_OFS = 8'h04;
   localparam logic [7:0] DIS2_OFS = 8'h08;
   localparam logic [7:0] SECT_SEL_OFS = 8'h0C;
   localparam logic [7:0] SECT_CFG_OFS = 8'h10;
   localparam logic [7:0] REQ_OFS = 8'h14;
   localparam logic [7:0] OUT_STAT_OFS = 8'h18;
   localparam logic [7:0] LOCK_STAT_OFS = 8'h1C;
   localparam logic [7:0] ALM_SEL_OFS = 8'h20;
   localparam logic [7:0] ALM_CFG_OFS = 8'h24;
   localparam logic [7:0] ALM_STAT_OFS = 8'h28;
   localparam logic [7:0] AOR_OFS = 8'h2C;
   // field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SET2_LSB = 8;
   localparam int MMSS_SS_LSB = 0;
   localparam int MMSS_MM_LSB = 8;
   localparam int REQ_ON_BIT = 0;
   localparam int REQ_OFF_BIT = 1;
   localparam int REQ_CLOSE_BIT = 2;
   localparam int REQ_OPEN_BIT = 3;
   localparam int REQ_IDX_LSB = 8;
   localparam int ALM_STAT_GEN_BIT = 31;
   localparam int AOR_START_BIT = 0;
   localparam int AOR_STOP_BIT = 1;
   localparam int AOR_REFUSED_BIT = 2;
   // switching mode codes
   localparam logic [1:0] MODE_FREE = 2'h0;
   localparam logic [1:0] MODE_ROUND = 2'h1;
   localparam logic [1:0] MODE_LINEAR = 2'h2;
   typedef enum logic [1:0] {
      COS_DUTY_CTRL = 2'h0,
      COS_DUTY_FIX_ON = 2'h1,
      COS_DUTY_FIX_OFF = 2'h2,
      COS_DUTY_ALARM = 2'h3
   } cos_duty_t;
   typedef struct packed {
      logic act_high;    // alarm duty: level while indication active
      logic cap;         // capacitor character, subject to lockout
      logic [2:0] phase; // non-zero reactive part on L3..L1
      cos_duty_t duty;
   } cos_sect_cfg_t;
   typedef struct packed {
      logic phase_sel;   // per-phase control quantity
      logic use_avg;     // evaluate averaged value
      logic [1:0] en;    // bit0 indication, bit1 actuation
      logic [7:0] mm;
      logic [7:0] ss;
   } cos_alm_cfg_t;
   typedef struct packed {
      logic [N_ALARM-1:0][2:0] phase;
      logic [N_ALARM-1:0] cond_avg;
      logic [N_ALARM-1:0] cond_act;
   } cos_alm_in_t;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] DIS_RST = 16'h0014;
   localparam cos_sect_cfg_t SECT_CFG_RST = 7'h7C;
   localparam cos_alm_cfg_t ALM_CFG_RST = 20'h0_0001;

   function automatic logic [TW-1:0] cos_mmss(input logic [7:0] mm, input logic [7:0] ss);
      return TW'(mm) * TW'(60) + TW'(ss);
   endfunction
endpackage

// [cos_sec_timer.sv]
// one-second down counter used for lockouts and alarm persistence
`timescale 1ns/100ps
`default_nettype none
module cos_sec_timer
#(
   parameter int W = 14
)
(
   input wire logic mclk,           // system clock
   input wire logic nrst,           // async reset, active low
   input wire logic load,           // restart with load_val
   input wire logic [W-1:0] load_val, // seconds
   input wire logic tick,           // one pulse per second
   output logic zero                // count has run out
);
   logic [W-1:0] cnt_reg;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         cnt_reg <= '0;
      else if (load)
         cnt_reg <= load_val;
      else if (tick && cnt_reg != '0)
         cnt_reg <= cnt_reg - W'(1);
   end

   assign zero = (cnt_reg == '0);
endmodule // cos_sec_timer
`default_nettype wire

// [cos_sequencer.sv]
// compensation output sequencer: lockout, switching order, alarm evaluation, apb registers
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - capacitor output switched off cannot reclose until discharge time elapsed; alarm-duty outputs are not held open.
// - during lockout output stays open; automatic and manual close refused; alarm-duty outputs still follow indication.
// - set 2 off: set 1 discharge time for all, set 2 time hidden.
// - set 2 on: set 1 outputs use time 1, set 2 outputs time 2.
// - boundary names first set-2 output; lower outputs set 1; zero means off.
// - discharge times held as minutes and seconds.
// - free order mode picks outputs freely, balancing wear for lifetime.
// - round robin connect picks section disconnected longest.
// - round robin disconnect picks section connected longest.
// - linear connect closes lowest-numbered open control section.
// - linear disconnect opens highest-numbered closed control section.
// - only non-zero, non-fixed, non-alarm sections are control sections; others skipped.
// - linear mode disables automatic recognition and refuses its start.
// - each alarm has two-bit enable: off, indication, actuation, both.
// - indication enabled and condition persisting raises flashing general alarm.
// - active indication drives alarm-duty outputs to their configured level.
// - indication alone never alters the control process.
// - actuation interrupts control and disconnects all sections; alarm-duty sections keep following indication.
// - per-phase actuation disconnects only sections with reactive part on that phase.
// - alarms numbered consecutively from one, voltage loss first.
// - each alarm selects actual or averaged control quantity.
// - alarm changes state only after condition held for delay, both directions.
// - per-alarm active flag kept apart from general indication.
module cos_sequencer
   import cos_pkg::*;
#(
   parameter int TICK_CYCLES_P = cos_pkg::TICK_CYCLES
)
(
   input wire logic mclk,                        // 250 MHz clock
   input wire logic nrst,                        // async reset, active low
   input wire logic [7:0] paddr,                 // apb address
   input wire logic psel,                        // apb select
   input wire logic penable,                     // apb enable
   input wire logic pwrite,                      // apb direction
   input wire logic [31:0] pwdata,               // apb write data
   output logic [31:0] prdata,                   // apb read data
   output logic pready,                          // apb ready
   output logic pslverr,                         // apb error
   input wire cos_pkg::cos_alm_in_t alarm_in,    // alarm conditions
   output logic [cos_pkg::N_SECT-1:0] sect_out,  // contactor drives
   output logic alarm_flash,                     // flashing general alarm
   output logic control_halt,                    // control interrupted
   output logic aor_enable                       // recognition allowed
);
   import cos_pkg::*;

   logic [27:0] tick_cnt_reg;
   logic sec_tick_reg;
   logic blink_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata_next;
   logic err_next;
   logic setup_phase;
   logic wr_en;
   logic [1:0] mode_reg;
   logic [IW-1:0] set2_first_reg;
   logic [15:0] dis1_reg;
   logic [15:0] dis2_reg;
   logic [IW-1:0] sect_sel_reg;
   logic [IW-1:0] alm_sel_reg;
   cos_sect_cfg_t sect_cfg_reg [N_SECT];
   cos_alm_cfg_t alm_cfg_reg [N_ALARM];
   logic req_on_reg;
   logic req_off_reg;
   logic req_close_reg;
   logic req_open_reg;
   logic [IW-1:0] req_idx_reg;
   logic aor_run_reg;
   logic aor_refused_reg;
   logic aor_enable_reg;
   logic halt_reg;
   logic flash_reg;
   logic [N_SECT-1:0] sect_reg;
   logic [N_SECT-1:0] sect_next;
   logic [KW-1:0] seq_reg;
   logic [KW-1:0] stamp_reg [N_SECT];
   logic [KW-1:0] swcnt_reg [N_SECT];
   logic [N_SECT-1:0] lock_zero;
   logic [N_SECT-1:0] lock_load;
   logic [TW-1:0] lock_val [N_SECT];
   logic [N_SECT-1:0] is_ctrl;
   logic [N_SECT-1:0] blocked;
   logic halt_next;
   logic [N_ALARM-1:0] alm_state_reg;
   logic [N_ALARM-1:0] alm_cond;
   logic [N_ALARM-1:0] alm_load;
   logic [N_ALARM-1:0] alm_zero;
   logic ind_active;
   logic on_found;
   logic off_found;
   logic [IW-1:0] on_idx;
   logic [IW-1:0] off_idx;
   logic [KW-1:0] best_on;
   logic [KW-1:0] best_off;
   logic [KW-1:0] key_on;
   logic [KW-1:0] key_off;
   logic [IW-1:0] alm_idx;

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign sect_out = sect_reg;
   assign alarm_flash = flash_reg;
   assign control_halt = halt_reg;
   assign aor_enable = aor_enable_reg;

   // one-second time base; shorten TICK_CYCLES_P in simulation
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         tick_cnt_reg <= '0;
         sec_tick_reg <= 1'b0;
         blink_reg <= 1'b0;
      end
      else if (tick_cnt_reg == 28'(TICK_CYCLES_P - 1))
      begin
         tick_cnt_reg <= '0;
         sec_tick_reg <= 1'b1;
         blink_reg <= ~blink_reg;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_reg + 28'h1;
         sec_tick_reg <= 1'b0;
      end
   end

   // apb: ready comes one cycle after setup, so read data can be registered
   assign setup_phase = psel & ~penable & ~pready_reg;
   assign wr_en = psel & penable & pready_reg & pwrite & ~pslverr_reg;
   assign alm_idx = (alm_sel_reg == '0) ? '0 : alm_sel_reg - IW'(1);

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      err_next = 1'b0;
      if (paddr == CTRL_OFS)
      begin
         rdata_next[CTRL_MODE_LSB +: 2] = mode_reg;
         rdata_next[CTRL_SET2_LSB +: IW] = set2_first_reg;
      end
      else if (paddr == DIS1_OFS)
         rdata_next[15:0] = dis1_reg;
      else if (paddr == DIS2_OFS)
         rdata_next[15:0] = (set2_first_reg != '0) ? dis2_reg : 16'h0000;
      else if (paddr == SECT_SEL_OFS)
         rdata_next[IW-1:0] = sect_sel_reg;
      else if (paddr == SECT_CFG_OFS)
         rdata_next[$bits(cos_sect_cfg_t)-1:0] = (sect_sel_reg < IW'(N_SECT)) ? sect_cfg_reg[sect_sel_reg] : '0;
      else if (paddr == REQ_OFS)
         rdata_next = 32'h0000_0000;
      else if (paddr == OUT_STAT_OFS)
         rdata_next[N_SECT-1:0] = sect_reg;
      else if (paddr == LOCK_STAT_OFS)
         rdata_next[N_SECT-1:0] = ~lock_zero;
      else if (paddr == ALM_SEL_OFS)
         rdata_next[IW-1:0] = alm_sel_reg;
      else if (paddr == ALM_CFG_OFS)
         rdata_next[$bits(cos_alm_cfg_t)-1:0] = (alm_idx < IW'(N_ALARM)) ? alm_cfg_reg[alm_idx] : '0;
      else if (paddr == ALM_STAT_OFS)
      begin
         rdata_next[N_ALARM-1:0] = alm_state_reg;
         rdata_next[ALM_STAT_GEN_BIT] = ind_active;
      end
      else if (paddr == AOR_OFS)
      begin
         rdata_next[AOR_START_BIT] = aor_run_reg;
         rdata_next[AOR_REFUSED_BIT] = aor_refused_reg;
      end
      else
         err_next = 1'b1;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end
      else if (setup_phase)
      begin
         pready_reg <= 1'b1;
         pslverr_reg <= err_next;
         prdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
      end
      else
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // configuration registers
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_reg <= CTRL_RST[CTRL_MODE_LSB +: 2];
         set2_first_reg <= CTRL_RST[CTRL_SET2_LSB +: IW];
         dis1_reg <= DIS_RST;
         dis2_reg <= DIS_RST;
         sect_sel_reg <= '0;
         alm_sel_reg <= '0;
         for (int i = 0; i < N_SECT; i++)
            sect_cfg_reg[i] <= SECT_CFG_RST;
         for (int a = 0; a < N_ALARM; a++)
            alm_cfg_reg[a] <= ALM_CFG_RST;
      end
      else if (wr_en)
      begin
         if (paddr == CTRL_OFS)
         begin
            mode_reg <= pwdata[CTRL_MODE_LSB +: 2];
            set2_first_reg <= pwdata[CTRL_SET2_LSB +: IW];
         end
         else if (paddr == DIS1_OFS)
            dis1_reg <= pwdata[15:0];
         else if (paddr == DIS2_OFS)
            dis2_reg <= pwdata[15:0];
         else if (paddr == SECT_SEL_OFS)
            sect_sel_reg <= pwdata[IW-1:0];
         else if (paddr == SECT_CFG_OFS && sect_sel_reg < IW'(N_SECT))
            sect_cfg_reg[sect_sel_reg] <= pwdata[$bits(cos_sect_cfg_t)-1:0];
         else if (paddr == ALM_SEL_OFS)
            alm_sel_reg <= pwdata[IW-1:0];
         else if (paddr == ALM_CFG_OFS && alm_idx < IW'(N_ALARM))
            alm_cfg_reg[alm_idx] <= pwdata[$bits(cos_alm_cfg_t)-1:0];
      end
   end

   // switching requests live for one cycle
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         req_on_reg <= 1'b0;
         req_off_reg <= 1'b0;
         req_close_reg <= 1'b0;
         req_open_reg <= 1'b0;
         req_idx_reg <= '0;
      end
      else
      begin
         req_on_reg <= wr_en && paddr == REQ_OFS && pwdata[REQ_ON_BIT];
         req_off_reg <= wr_en && paddr == REQ_OFS && pwdata[REQ_OFF_BIT];
         req_close_reg <= wr_en && paddr == REQ_OFS && pwdata[REQ_CLOSE_BIT];
         req_open_reg <= wr_en && paddr == REQ_OFS && pwdata[REQ_OPEN_BIT];
         if (wr_en && paddr == REQ_OFS)
            req_idx_reg <= pwdata[REQ_IDX_LSB +: IW];
      end
   end

   // automatic section recognition gate
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         aor_run_reg <= 1'b0;
         aor_refused_reg <= 1'b0;
         aor_enable_reg <= 1'b0;
      end
      else
      begin
         aor_enable_reg <= (mode_reg != MODE_LINEAR);
         if (mode_reg == MODE_LINEAR)
            aor_run_reg <= 1'b0;
         else if (wr_en && paddr == AOR_OFS && pwdata[AOR_STOP_BIT])
            aor_run_reg <= 1'b0;
         else if (wr_en && paddr == AOR_OFS && pwdata[AOR_START_BIT])
            aor_run_reg <= 1'b1;
         if (wr_en && paddr == AOR_OFS && pwdata[AOR_START_BIT])
            aor_refused_reg <= (mode_reg == MODE_LINEAR);
      end
   end

   // alarm evaluation; a disabled alarm is driven back to passive
   genvar ga;
   generate
      for (ga = 0; ga < N_ALARM; ga++)
      begin : g_alarm
         assign alm_cond[ga] = (alm_cfg_reg[ga].en != 2'b00) &&
            (alm_cfg_reg[ga].use_avg ? alarm_in.cond_avg[ga] : alarm_in.cond_act[ga]);
         assign alm_load[ga] = (alm_cond[ga] == alm_state_reg[ga]);
         cos_sec_timer #(.W(TW)) u_persist
         (
            .mclk(mclk),
            .nrst(nrst),
            .load(alm_load[ga]),
            .load_val(cos_mmss(alm_cfg_reg[ga].mm, alm_cfg_reg[ga].ss)),
            .tick(sec_tick_reg),
            .zero(alm_zero[ga])
         );
      end
   endgenerate

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         alm_state_reg <= '0;
      else
         alm_state_reg <= alm_state_reg ^ (~alm_load & alm_zero);
   end

   always_comb
   begin
      ind_active = 1'b0;
      halt_next = 1'b0;
      blocked = '0;
      for (int a = 0; a < N_ALARM; a++)
      begin
         if (alm_state_reg[a] && alm_cfg_reg[a].en[0])
            ind_active = 1'b1;
         if (alm_state_reg[a] && alm_cfg_reg[a].en[1])
         begin
            if (alm_cfg_reg[a].phase_sel)
            begin
               for (int i = 0; i < N_SECT; i++)
                  if ((sect_cfg_reg[i].phase & alarm_in.phase[a]) != 3'b000)
                     blocked[i] = 1'b1;
            end
            else
            begin
               halt_next = 1'b1;
               blocked = '1;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         halt_reg <= 1'b0;
         flash_reg <= 1'b0;
      end
      else
      begin
         halt_reg <= halt_next;
         flash_reg <= ind_active & blink_reg;
      end
   end

   // discharge lockout per output
   genvar gs;
   generate
      for (gs = 0; gs < N_SECT; gs++)
      begin : g_sect
         assign is_ctrl[gs] = sect_cfg_reg[gs].duty == COS_DUTY_CTRL && sect_cfg_reg[gs].phase != 3'b000;
         // outputs numbered from one; zero boundary keeps everything in set 1
         assign lock_val[gs] = (set2_first_reg != '0 && IW'(gs + 1) >= set2_first_reg) ?
            cos_mmss(dis2_reg[MMSS_MM_LSB +: 8], dis2_reg[MMSS_SS_LSB +: 8]) :
            cos_mmss(dis1_reg[MMSS_MM_LSB +: 8], dis1_reg[MMSS_SS_LSB +: 8]);
         assign lock_load[gs] = sect_cfg_reg[gs].cap & sect_reg[gs] & ~sect_next[gs];
         cos_sec_timer #(.W(TW)) u_lock
         (
            .mclk(mclk),
            .nrst(nrst),
            .load(lock_load[gs]),
            .load_val(lock_val[gs]),
            .tick(sec_tick_reg),
            .zero(lock_zero[gs])
         );
      end
   endgenerate

   // candidate search: a connect key and a disconnect key per mode, smallest key wins
   always_comb
   begin
      on_found = 1'b0;
      off_found = 1'b0;
      on_idx = '0;
      off_idx = '0;
      best_on = '1;
      best_off = '1;
      key_on = '0;
      key_off = '0;
      for (int i = 0; i < N_SECT; i++)
      begin
         if (mode_reg == MODE_LINEAR)
         begin
            key_on = KW'(i);
            key_off = KW'(N_SECT - 1 - i);
         end
         else if (mode_reg == MODE_ROUND)
         begin
            key_on = stamp_reg[i];
            key_off = stamp_reg[i];
         end
         else
         begin
            key_on = swcnt_reg[i];
            key_off = stamp_reg[i];
         end
         if (is_ctrl[i] && !sect_reg[i] && lock_zero[i] && !blocked[i] && (!on_found || key_on < best_on))
         begin
            on_found = 1'b1;
            on_idx = IW'(i);
            best_on = key_on;
         end
         if (is_ctrl[i] && sect_reg[i] && (!off_found || key_off < best_off))
         begin
            off_found = 1'b1;
            off_idx = IW'(i);
            best_off = key_off;
         end
      end
   end

   // next output state; alarm indication only touches alarm-duty outputs
   always_comb
   begin
      sect_next = sect_reg;
      if (req_on_reg && on_found && !halt_next)
         sect_next[on_idx] = 1'b1;
      if (req_off_reg && off_found && !halt_next)
         sect_next[off_idx] = 1'b0;
      for (int i = 0; i < N_SECT; i++)
      begin
         if (req_close_reg && req_idx_reg == IW'(i) && sect_cfg_reg[i].duty == COS_DUTY_CTRL)
            sect_next[i] = 1'b1;
         if (req_open_reg && req_idx_reg == IW'(i) && sect_cfg_reg[i].duty == COS_DUTY_CTRL)
            sect_next[i] = 1'b0;
         case (sect_cfg_reg[i].duty)
            COS_DUTY_FIX_ON: sect_next[i] = 1'b1;
            COS_DUTY_FIX_OFF: sect_next[i] = 1'b0;
            COS_DUTY_ALARM: sect_next[i] = ind_active ~^ sect_cfg_reg[i].act_high;
            default: sect_next[i] = sect_next[i];
         endcase
         if (blocked[i] && sect_cfg_reg[i].duty != COS_DUTY_ALARM)
            sect_next[i] = 1'b0;
         // a locked output other than an alarm-duty one may stay open but never close
         if (sect_cfg_reg[i].cap && !lock_zero[i] && !sect_reg[i] && sect_cfg_reg[i].duty != COS_DUTY_ALARM)
            sect_next[i] = 1'b0;
      end
   end

   // stamps order switching age; wrap after 65536 operations may misorder once
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         sect_reg <= '0;
         seq_reg <= '0;
         for (int i = 0; i < N_SECT; i++)
         begin
            stamp_reg[i] <= '0;
            swcnt_reg[i] <= '0;
         end
      end
      else
      begin
         sect_reg <= sect_next;
         if (sect_next != sect_reg)
            seq_reg <= seq_reg + KW'(1);
         for (int i = 0; i < N_SECT; i++)
         begin
            if (sect_next[i] != sect_reg[i])
               stamp_reg[i] <= seq_reg;
            if (sect_next[i] && !sect_reg[i] && swcnt_reg[i] != '1)
               swcnt_reg[i] <= swcnt_reg[i] + KW'(1);
         end
      end
   end
endmodule // cos_sequencer
`default_nettype wire

// [cos_sequencer_sva.sv]
// port assertions for the compensation output sequencer
`timescale 1ns/100ps
`default_nettype none
module cos_sequencer_sva
   import cos_pkg::*;
#(
   parameter int TICK_CYCLES_P = 10
)
(
   input wire logic mclk, // clock
   input wire logic nrst, // reset
   input wire logic [7:0] paddr, // address
   input wire logic psel, // select
   input wire logic penable, // enable
   input wire logic pwrite, // direction
   input wire logic [31:0] pwdata, // write data
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire cos_pkg::cos_alm_in_t alarm_in, // alarms
   input wire logic [cos_pkg::N_SECT-1:0] sect_out, // drives
   input wire logic alarm_flash, // flash
   input wire logic control_halt, // halt
   input wire logic aor_enable // aor gate
);
   // output 1 on set-1 reset time, less one tick phase
   localparam int LOCK_MIN = 19 * TICK_CYCLES_P;
   localparam int FLASH_MAX = TICK_CYCLES_P + 1;
   logic [15:0] off_cnt_reg;
   logic wr_lin;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   assign wr_lin = psel && penable && pready && pwrite && paddr == CTRL_OFS && pwdata[1:0] == MODE_LINEAR;
   // full: no lockout at power-up
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         off_cnt_reg <= 16'hFFFF;
      else if ($fell(sect_out[0]))
         off_cnt_reg <= 16'h0001;
      else if (off_cnt_reg != 16'hFFFF)
         off_cnt_reg <= off_cnt_reg + 16'h0001;
   end
   property p_rdy_follows;
      psel && !penable |=> pready;
   endproperty
   property p_rdy_access;
      pready |-> psel && penable;
   endproperty
   property p_err_rdy;
      pslverr |-> pready;
   endproperty
   property p_aor_off;
      wr_lin |-> ##[1:3] !aor_enable;
   endproperty
   property p_lock;
      $rose(sect_out[0]) |-> off_cnt_reg >= LOCK_MIN;
   endproperty
   property p_halt_clear;
      $rose(control_halt) |-> ##[0:2] sect_out == '0;
   endproperty
   property p_halt_hold;
      control_halt && $past(control_halt) |-> (sect_out & ~$past(sect_out)) == '0;
   endproperty
   property p_flash;
      alarm_flash |-> ##[1:FLASH_MAX] !alarm_flash;
   endproperty
   a_rdy_follows: assert property (p_rdy_follows) else $error("no ready after setup");
   a_rdy_access: assert property (p_rdy_access) else $error("ready outside access");
   a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
   a_aor_off: assert property (p_aor_off) else $error("recognition left on");
   a_lock: assert property (p_lock) else $error("output reclosed too early");
   a_halt_clear: assert property (p_halt_clear) else $error("sections kept on halt");
   a_halt_hold: assert property (p_halt_hold) else $error("section closed in halt");
   a_flash: assert property (p_flash) else $error("alarm not flashing");
   c_linear: cover property (wr_lin);
   c_halt: cover property ($rose(control_halt));
   c_flash: cover property ($rose(alarm_flash));
endmodule // cos_sequencer_sva
bind cos_sequencer cos_sequencer_sva #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_sva (.*);
`default_nettype wire

// [test_compensation_output_sequencer.sv]
// self-checking bench for the compensation output sequencer
`timescale 1ns/100ps
`default_nettype none
module test_compensation_output_sequencer;
   import cos_pkg::*;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr, alarm_flash, control_halt, aor_enable, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [N_SECT-1:0] sect_out, closed;
   cos_alm_in_t alarm_in;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   cos_sequencer #(.TICK_CYCLES_P(10)) u_dut (.*);
   cos_contactor_model #(.PULL_CYCLES(2)) u_bank (.mclk(mclk), .coil(sect_out), .closed(closed));
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         n_fail++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
         @(negedge mclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // request lands two edges after access
   task automatic req(input logic [31:0] d);
      wr(REQ_OFS, d);
      repeat (3) @(posedge mclk);
   endtask
   initial
   begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      alarm_in = '0;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      rc(CTRL_OFS, CTRL_RST);
      rc(DIS1_OFS, 32'h0000_0014);
      rc(DIS2_OFS, 32'h0);
      xfer(1'b0, 8'h3C, 32'h0);
      chk(32'(err), 32'h1);
      chk(32'(aor_enable), 32'h1);
      $display("test reset done");
      wr(CTRL_OFS, 32'(MODE_LINEAR));
      wr(AOR_OFS, 32'h1);
      rc(AOR_OFS, 32'h4);
      chk(32'(aor_enable), 32'h0);
      wr(SECT_SEL_OFS, 32'h1);
      wr(SECT_CFG_OFS, 32'h7E);
      req(32'h1);
      req(32'h1);
      chk(32'(sect_out), 32'h5);
      req(32'h2);
      chk(32'(sect_out), 32'h1);
      req(32'h0204);
      chk(32'(sect_out), 32'h1);
      rc(LOCK_STAT_OFS, 32'h4);
      repeat (200) @(posedge mclk);
      req(32'h0204);
      chk(32'(sect_out), 32'h5);
      $display("test linear done");
      wr(CTRL_OFS, 32'h0302);
      wr(DIS2_OFS, 32'h0005);
      rc(DIS2_OFS, 32'h0005);
      req(32'h2);
      req(32'h2);
      repeat (70) @(posedge mclk);
      req(32'h0204);
      req(32'h0004);
      chk(32'(sect_out), 32'h4);
      repeat (200) @(posedge mclk);
      req(32'h1);
      chk(32'(sect_out), 32'h5);
      wr(CTRL_OFS, 32'(MODE_ROUND));
      req(32'h2);
      chk(32'(sect_out), 32'h1);
      $display("test sets done");
      wr(SECT_SEL_OFS, 32'h11);
      wr(SECT_CFG_OFS, 32'h7F);
      wr(ALM_SEL_OFS, 32'h2);
      wr(ALM_CFG_OFS, 32'h0001_0003);
      alarm_in.cond_act[1] <= 1'b1;
      repeat (5) @(posedge mclk);
      alarm_in.cond_act[1] <= 1'b0;
      repeat (45) @(posedge mclk);
      rc(ALM_STAT_OFS, 32'h0);
      alarm_in.cond_act[1] <= 1'b1;
      repeat (45) @(posedge mclk);
      rc(ALM_STAT_OFS, 32'h8000_0002);
      chk(32'(closed), 32'h2_0001);
      chk(32'(control_halt), 32'h0);
      alarm_in.cond_act[1] <= 1'b0;
      repeat (45) @(posedge mclk);
      rc(ALM_STAT_OFS, 32'h0);
      chk(32'(sect_out), 32'h1);
      wr(SECT_CFG_OFS, 32'h7C);
      wr(ALM_CFG_OFS, 32'h0002_0003);
      alarm_in.cond_act[1] <= 1'b1;
      repeat (45) @(posedge mclk);
      chk(32'(control_halt), 32'h1);
      chk(32'(closed), 32'h0);
      chk(32'(alarm_flash), 32'h0);
      rc(ALM_STAT_OFS, 32'h2);
      req(32'h1);
      chk(32'(sect_out), 32'h0);
      alarm_in.cond_act[1] <= 1'b0;
      wr(ALM_CFG_OFS, 32'h0005_0003);
      repeat (45) @(posedge mclk);
      alarm_in.cond_act[1] <= 1'b1;
      repeat (45) @(posedge mclk);
      rc(ALM_STAT_OFS, 32'h0);
      chk(32'(control_halt), 32'h0);
      $display("test alarms done");
      finish_test();
   end
endmodule // test_compensation_output_sequencer
`default_nettype wire
